// >>> core/sagc_core.sv
`timescale 1ns/1ns
module sagc_core #(
  parameter int CLK_MHZ = sagc_pkg::SAGC_CLK_MHZ,
  parameter int STEPS_PER_6DB = sagc_pkg::SAGC_STEPS_PER_6DB,
  parameter int ATT_W = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic [5:0] speaker_gain_setting,
  input wire logic signed [12:0] headroom_mv,
  input wire logic powerlimit_over,
  input wire logic zero_cross,
  input wire logic voice_bypass_in,
  output logic voice_bypass_out,
  output logic [5:0] speaker_gain_stage,
  output logic half_db_cut,
  output logic signed [7:0] speaker_gain_db,
  output logic anticlip_active
);

  // ==========================================================================
  // Control registers
  // ==========================================================================
  logic autogain_enable_q;
  logic single_step_per_crossing_q;
  logic [5:0] attenuation_floor_gain_q;
  logic anticlip_enable_q;
  logic [3:0] headroom_threshold_q;
  logic [2:0] anticlip_attack_rate_q;
  logic [2:0] anticlip_decay_rate_q;
  logic powerlimit_enable_q;
  logic [2:0] powerlimit_attack_rate_q;
  logic [2:0] powerlimit_decay_rate_q;

  // Writes land on the documented offsets; unknown offsets are ignored.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      autogain_enable_q <= sagc_pkg::SAGC_AUTOGAIN_ENABLE_RST;
      single_step_per_crossing_q <= sagc_pkg::SAGC_SINGLE_STEP_RST;
      attenuation_floor_gain_q <= sagc_pkg::SAGC_FLOOR_RST;
      anticlip_enable_q <= sagc_pkg::SAGC_ANTICLIP_ENABLE_RST;
      headroom_threshold_q <= sagc_pkg::SAGC_THRESHOLD_RST;
      anticlip_attack_rate_q <= sagc_pkg::SAGC_ATTACK_RST;
      anticlip_decay_rate_q <= sagc_pkg::SAGC_DECAY_RST;
      powerlimit_enable_q <= sagc_pkg::SAGC_POWERLIMIT_ENABLE_RST;
      powerlimit_attack_rate_q <= sagc_pkg::SAGC_PL_ATTACK_RST;
      powerlimit_decay_rate_q <= sagc_pkg::SAGC_PL_DECAY_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == sagc_pkg::SAGC_POWER_MANAGEMENT_THREE_OFS)
      begin
        autogain_enable_q <= reg_wdata[sagc_pkg::SAGC_AUTOGAIN_ENABLE_BIT];
      end
      else if (reg_addr == sagc_pkg::SAGC_ANTICLIP_CONTROL_OFS)
      begin
        anticlip_enable_q <= reg_wdata[sagc_pkg::SAGC_ANTICLIP_ENABLE_BIT];
        headroom_threshold_q <= reg_wdata[sagc_pkg::SAGC_THRESHOLD_LSB +: 4];
        anticlip_attack_rate_q <= reg_wdata[sagc_pkg::SAGC_ATTACK_LSB +: 3];
        anticlip_decay_rate_q <= reg_wdata[sagc_pkg::SAGC_DECAY_LSB +: 3];
      end
      else if (reg_addr == sagc_pkg::SAGC_POWERLIMIT_CONTROL_OFS)
      begin
        powerlimit_enable_q <= reg_wdata[sagc_pkg::SAGC_POWERLIMIT_ENABLE_BIT];
        powerlimit_attack_rate_q <= reg_wdata[sagc_pkg::SAGC_PL_ATTACK_LSB +: 3];
        powerlimit_decay_rate_q <= reg_wdata[sagc_pkg::SAGC_PL_DECAY_LSB +: 3];
      end
      else if (reg_addr == sagc_pkg::SAGC_GAIN_CONTROL_RAMP_AND_FLOOR_OFS)
      begin
        single_step_per_crossing_q <= reg_wdata[sagc_pkg::SAGC_SINGLE_STEP_BIT];
        attenuation_floor_gain_q <= reg_wdata[sagc_pkg::SAGC_FLOOR_LSB +: 6];
      end
    end
  end

  // Read mux; other bits of the power register belong to other blocks.
  always_comb
  begin
    reg_rdata = 16'h0000;
    if (reg_addr == sagc_pkg::SAGC_POWER_MANAGEMENT_THREE_OFS)
    begin
      reg_rdata[sagc_pkg::SAGC_AUTOGAIN_ENABLE_BIT] = autogain_enable_q;
    end
    else if (reg_addr == sagc_pkg::SAGC_ANTICLIP_CONTROL_OFS)
    begin
      reg_rdata[sagc_pkg::SAGC_ANTICLIP_ENABLE_BIT] = anticlip_enable_q;
      reg_rdata[sagc_pkg::SAGC_THRESHOLD_LSB +: 4] = headroom_threshold_q;
      reg_rdata[sagc_pkg::SAGC_ATTACK_LSB +: 3] = anticlip_attack_rate_q;
      reg_rdata[sagc_pkg::SAGC_DECAY_LSB +: 3] = anticlip_decay_rate_q;
    end
    else if (reg_addr == sagc_pkg::SAGC_POWERLIMIT_CONTROL_OFS)
    begin
      reg_rdata[sagc_pkg::SAGC_POWERLIMIT_ENABLE_BIT] = powerlimit_enable_q;
      reg_rdata[sagc_pkg::SAGC_PL_ATTACK_LSB +: 3] = powerlimit_attack_rate_q;
      reg_rdata[sagc_pkg::SAGC_PL_DECAY_LSB +: 3] = powerlimit_decay_rate_q;
    end
    else if (reg_addr == sagc_pkg::SAGC_GAIN_CONTROL_RAMP_AND_FLOOR_OFS)
    begin
      reg_rdata[sagc_pkg::SAGC_SINGLE_STEP_BIT] = single_step_per_crossing_q;
      reg_rdata[sagc_pkg::SAGC_FLOOR_LSB +: 6] = attenuation_floor_gain_q;
    end
  end

  // ==========================================================================
  // Detection
  // ==========================================================================
  logic signed [12:0] threshold_mv;
  logic clip_hit;
  logic power_hit;

  always_comb
  begin
    if (headroom_threshold_q <= 4'(sagc_pkg::SAGC_THR_KNEE_CODE))
    begin
      threshold_mv = 13'(sagc_pkg::SAGC_THR_BASE_MV
        + sagc_pkg::SAGC_THR_FINE_MV * int'(headroom_threshold_q));
    end
    else
    begin
      threshold_mv = 13'(sagc_pkg::SAGC_THR_BASE_MV
        + sagc_pkg::SAGC_THR_FINE_MV * sagc_pkg::SAGC_THR_KNEE_CODE
        + sagc_pkg::SAGC_THR_COARSE_MV
        * (int'(headroom_threshold_q) - sagc_pkg::SAGC_THR_KNEE_CODE));
    end
  end

  assign clip_hit = anticlip_enable_q && (headroom_mv <= threshold_mv);
  assign power_hit = powerlimit_enable_q && powerlimit_over;
  assign anticlip_active = clip_hit;

  // ==========================================================================
  // Rate selection
  // ==========================================================================
  sagc_pkg::sagc_mode_e mode;
  logic clip_seen_q;
  logic power_seen_q;
  logic [31:0] period;
  logic step_tick;
  logic [ATT_W-1:0] att_q;
  logic [ATT_W-1:0] pending_q;
  logic [ATT_W-1:0] att_max;
  logic [ATT_W-1:0] apply_steps;

  // Remember whether anti-clip took part in the current attenuation episode.
  // A hit in the cycle that the first step lands must still count, so set wins.
  always_ff @(posedge sys_clk)
  begin
    if (rst || !autogain_enable_q)
    begin
      clip_seen_q <= 1'b0;
    end
    else if (clip_hit)
    begin
      clip_seen_q <= 1'b1;
    end
    else if (att_q == '0)
    begin
      clip_seen_q <= 1'b0;
    end
  end

  // Rates are tabled as time per 6 dB; one step interval is that over 12.
  function automatic logic [31:0] attack_cycles(input logic [2:0] code);
    attack_cycles = 32'(sagc_pkg::SAGC_ATK_TENTH_MS[code] * CLK_MHZ * 100
      / STEPS_PER_6DB);
  endfunction

  function automatic logic [31:0] decay_cycles(input logic [2:0] code);
    decay_cycles = 32'(longint'(sagc_pkg::SAGC_DCY_MS[code]) * CLK_MHZ
      * sagc_pkg::SAGC_US_PER_MS / STEPS_PER_6DB);
  endfunction

  always_comb
  begin
    mode = sagc_pkg::SAGC_IDLE;
    period = 32'h00000001;
    if (clip_hit)
    begin
      mode = sagc_pkg::SAGC_ATTACK;
      period = attack_cycles(anticlip_attack_rate_q);
    end
    else if (power_hit)
    begin
      mode = sagc_pkg::SAGC_ATTACK;
      period = attack_cycles(powerlimit_attack_rate_q);
    end
    else if (att_q != '0)
    begin
      mode = sagc_pkg::SAGC_DECAY;
      if (clip_seen_q && !power_seen_q)
      begin
        period = decay_cycles(anticlip_decay_rate_q);
      end
      else
      begin
        period = decay_cycles(powerlimit_decay_rate_q);
      end
    end
  end

  // Remember whether power limiting took part in the current episode.
  always_ff @(posedge sys_clk)
  begin
    if (rst || !autogain_enable_q)
    begin
      power_seen_q <= 1'b0;
    end
    else if (power_hit)
    begin
      power_seen_q <= 1'b1;
    end
    else if (att_q == '0)
    begin
      power_seen_q <= 1'b0;
    end
  end

  sagc_rate_timer #(
    .CW(32)
  ) u_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(autogain_enable_q && mode != sagc_pkg::SAGC_IDLE),
    .period(period),
    .tick(step_tick)
  );

  // ==========================================================================
  // Attenuation tracking
  // ==========================================================================
  // floor limit
  assign att_max = (speaker_gain_setting > attenuation_floor_gain_q)
    ? ATT_W'((speaker_gain_setting - attenuation_floor_gain_q)
      * sagc_pkg::SAGC_HALF_DB_PER_CODE)
    : '0;

  assign apply_steps = (single_step_per_crossing_q && pending_q != '0)
    ? ATT_W'(1) : pending_q;

  // Steps accrue at the rate timer and are spent only on crossings.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pending_q <= '0;
    end
    else if (!autogain_enable_q || mode == sagc_pkg::SAGC_IDLE)
    begin
      pending_q <= '0;
    end
    else if (zero_cross)
    begin
      pending_q <= (pending_q - apply_steps) + ATT_W'(step_tick);
    end
    else if (step_tick && pending_q != '1)
    begin
      pending_q <= pending_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      att_q <= '0;
    end
    else if (!autogain_enable_q)
    begin
      att_q <= '0;
    end
    else if (att_q > att_max)
    begin
      att_q <= att_max;
    end
    else if (zero_cross && mode == sagc_pkg::SAGC_ATTACK)
    begin
      att_q <= (att_max - att_q > apply_steps) ? att_q + apply_steps : att_max;
    end
    else if (zero_cross && mode == sagc_pkg::SAGC_DECAY)
    begin
      att_q <= (att_q > apply_steps) ? att_q - apply_steps : '0;
    end
  end

  // ==========================================================================
  // Gain stage outputs
  // ==========================================================================
  logic [ATT_W-1:0] whole_db;

  // Whole dB rounds down and an odd count adds the half-dB cut, so every step
  // moves the level by exactly 0.5 dB.
  assign whole_db = att_q >> 1;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      speaker_gain_stage <= 6'h00;
      half_db_cut <= 1'b0;
      speaker_gain_db <= 8'h00;
    end
    else
    begin
      speaker_gain_stage <= speaker_gain_setting - 6'(whole_db);
      half_db_cut <= att_q[0];
      speaker_gain_db <= 8'(sagc_pkg::SAGC_GAIN_ZERO_DB + sagc_pkg::SAGC_GAIN_STEP_DB
        * (int'(speaker_gain_setting) - int'(whole_db)));
    end
  end

  assign voice_bypass_out = voice_bypass_in;

endmodule

// >>> core/sagc_pkg.sv
package sagc_pkg;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [7:0] SAGC_POWER_MANAGEMENT_THREE_OFS = 8'h03;
  localparam logic [7:0] SAGC_ANTICLIP_CONTROL_OFS = 8'h62;
  localparam logic [7:0] SAGC_POWERLIMIT_CONTROL_OFS = 8'h63;
  localparam logic [7:0] SAGC_GAIN_CONTROL_RAMP_AND_FLOOR_OFS = 8'h64;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int SAGC_AUTOGAIN_ENABLE_BIT = 14;
  localparam int SAGC_SINGLE_STEP_BIT = 8;
  localparam int SAGC_FLOOR_LSB = 0;
  localparam int SAGC_ANTICLIP_ENABLE_BIT = 15;
  localparam int SAGC_THRESHOLD_LSB = 8;
  localparam int SAGC_ATTACK_LSB = 4;
  localparam int SAGC_DECAY_LSB = 0;
  localparam int SAGC_POWERLIMIT_ENABLE_BIT = 15;
  localparam int SAGC_PL_ATTACK_LSB = 4;
  localparam int SAGC_PL_DECAY_LSB = 0;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic SAGC_AUTOGAIN_ENABLE_RST = 1'h0;
  localparam logic SAGC_SINGLE_STEP_RST = 1'h0;
  localparam logic [5:0] SAGC_FLOOR_RST = 6'h00;
  localparam logic SAGC_ANTICLIP_ENABLE_RST = 1'h1;
  localparam logic [3:0] SAGC_THRESHOLD_RST = 4'h6;
  localparam logic [2:0] SAGC_ATTACK_RST = 3'h4;
  localparam logic [2:0] SAGC_DECAY_RST = 3'h0;
  localparam logic SAGC_POWERLIMIT_ENABLE_RST = 1'h1;
  localparam logic [2:0] SAGC_PL_ATTACK_RST = 3'h0;
  localparam logic [2:0] SAGC_PL_DECAY_RST = 3'h0;

  // ==========================================================================
  // Gain coding and timing
  // ==========================================================================
  localparam int SAGC_GAIN_ZERO_DB = -57;
  localparam int SAGC_GAIN_STEP_DB = 1;
  localparam int SAGC_HALF_DB_PER_CODE = 2;
  localparam int SAGC_STEPS_PER_6DB = 12;
  localparam int SAGC_CLK_MHZ = 125;
  localparam int SAGC_US_PER_MS = 1000;
  // Headroom threshold table in millivolts.
  localparam int SAGC_THR_BASE_MV = -200;
  localparam int SAGC_THR_FINE_MV = 50;
  localparam int SAGC_THR_KNEE_CODE = 10;
  localparam int SAGC_THR_COARSE_MV = 100;
  // Attack times per 6 dB, tenths of a millisecond.
  localparam int SAGC_ATK_TENTH_MS [8] = '{6, 54, 102, 150, 198, 246, 294, 341};
  // Decay times per 6 dB, milliseconds.
  localparam int SAGC_DCY_MS [8] = '{120, 480, 820, 1170, 1640, 2050, 2730, 4100};

  typedef enum logic [1:0] {
    SAGC_IDLE,
    SAGC_ATTACK,
    SAGC_DECAY
  } sagc_mode_e;

endpackage

// >>> core/sagc_rate_timer.sv
`timescale 1ns/1ns
// ============================================================================
// Step rate timer
// ============================================================================
module sagc_rate_timer #(
  parameter int CW = 32
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [CW-1:0] period,
  output logic tick
);

  logic [CW-1:0] cnt_q;

  // Counts a step interval; restarts whenever the timer is stopped.
  always_ff @(posedge sys_clk)
  begin
    if (rst || !run)
    begin
      cnt_q <= '0;
      tick <= 1'b0;
    end
    else if (cnt_q + 1'b1 >= period)
    begin
      cnt_q <= '0;
      tick <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 1'b1;
      tick <= 1'b0;
    end
  end

endmodule

// >>> verif/sagc_core_assertions.sv
`timescale 1ns/1ns
// ============================================================
// Port checker
// ============================================================
module sagc_core_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_rdata,
  input wire logic [5:0] speaker_gain_setting,
  input wire logic signed [12:0] headroom_mv,
  input wire logic zero_cross,
  input wire logic voice_bypass_in,
  input wire logic voice_bypass_out,
  input wire logic [5:0] speaker_gain_stage,
  input wire logic half_db_cut,
  input wire logic signed [7:0] speaker_gain_db,
  input wire logic anticlip_active
);
  logic [2:0] busy_q;
  logic mapped;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Writes and setting changes may move the gain off a crossing.
  always_ff @(posedge sys_clk)
    busy_q <= {busy_q[1:0], rst | reg_wr | $changed(speaker_gain_setting)};
  // Offsets that answer a read.
  assign mapped = reg_addr inside {8'h03, 8'h62, 8'h63, 8'h64};
  function automatic int thr_mv(input logic [3:0] c);
    return (c <= 4'ha) ? -200 + 50 * int'(c) : 400 + 100 * (int'(c) - 11);
  endfunction
  sequence crossing_seen;
    $past(zero_cross) || $past(zero_cross, 2);
  endsequence
  chk_gain_ceiling: assert property (speaker_gain_stage <= $past(speaker_gain_setting))
    else $error("gain stage above software setting");
  chk_floor_kept: assert property (reg_addr == 8'h64 && !busy_q[0] |->
    speaker_gain_stage >= reg_rdata[5:0] || speaker_gain_stage == $past(speaker_gain_setting))
    else $error("gain stage below floor");
  chk_crossing_only: assert property (($changed(speaker_gain_stage) || $changed(half_db_cut))
    && busy_q == 3'h0 |-> crossing_seen)
    else $error("gain moved between crossings");
  chk_db_decode: assert property (!busy_q[0] |->
    speaker_gain_db == $signed({2'h0, speaker_gain_stage}) - 8'sd57)
    else $error("gain in dB does not match code");
  chk_bypass_path: assert property (voice_bypass_out == voice_bypass_in)
    else $error("voice bypass altered");
  chk_clip_threshold: assert property (anticlip_active && reg_addr == 8'h62 |->
    reg_rdata[15] && headroom_mv <= thr_mv(reg_rdata[11:8]))
    else $error("anti-clip raised above threshold");
  chk_reset_gain: assert property ($fell(rst) |=>
    speaker_gain_stage == $past(speaker_gain_setting) && !half_db_cut)
    else $error("gain not at setting after reset");
  chk_unmapped_zero: assert property (!mapped |-> reg_rdata == 16'h0000)
    else $error("unmapped offset read not zero");
endmodule

bind sagc_core sagc_core_checker sagc_core_checker_i (.sys_clk(sys_clk), .rst(rst),
  .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
  .speaker_gain_setting(speaker_gain_setting), .headroom_mv(headroom_mv),
  .zero_cross(zero_cross), .voice_bypass_in(voice_bypass_in),
  .voice_bypass_out(voice_bypass_out), .speaker_gain_stage(speaker_gain_stage),
  .half_db_cut(half_db_cut), .speaker_gain_db(speaker_gain_db),
  .anticlip_active(anticlip_active));

// >>> verif/sagc_far_model.sv
`timescale 1ns/1ns
// ============================================================
// Speaker stage and headroom detector model
// ============================================================
module sagc_far_model #(
  parameter int ZC_PERIOD = 16,
  parameter int MV_PER_CODE = 20
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [5:0] speaker_gain_stage,
  input wire logic signed [12:0] supply_mv,
  output logic signed [12:0] headroom_mv,
  output logic zero_cross
);
  logic [7:0] phase_q;
  // Swing grows with the applied code, so a cut opens headroom again.
  assign headroom_mv = supply_mv - 13'(MV_PER_CODE * speaker_gain_stage);
  // The signal crosses zero once per period, one cycle wide.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      phase_q <= 8'h00;
    else
      phase_q <= zero_cross ? 8'h00 : phase_q + 8'h01;
  end
  assign zero_cross = (phase_q == 8'(ZC_PERIOD - 1));
endmodule

// >>> verif/test_speaker_auto_gain_control.sv
`timescale 1ns/1ns
module test_speaker_auto_gain_control;
  logic sys_clk;
  logic rst;
  logic reg_wr;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [15:0] d;
  logic [5:0] speaker_gain_setting;
  logic signed [12:0] headroom_mv;
  logic signed [12:0] supply_mv;
  logic powerlimit_over;
  logic zero_cross;
  logic voice_bypass_in;
  logic voice_bypass_out;
  logic [5:0] speaker_gain_stage;
  logic half_db_cut;
  logic signed [7:0] speaker_gain_db;
  logic anticlip_active;
  logic ramp_watch;
  logic [6:0] level_q;
  logic [6:0] level_now;
  logic level_step;
  int big_drops;
  logic [31:0] lfsr;
  int bad_count;
  int checked;
  // A small clock scale keeps the rate timers short.
  sagc_core #(.CLK_MHZ(1)) sagc_core_i (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .speaker_gain_setting(speaker_gain_setting), .headroom_mv(headroom_mv),
    .powerlimit_over(powerlimit_over), .zero_cross(zero_cross),
    .voice_bypass_in(voice_bypass_in), .voice_bypass_out(voice_bypass_out),
    .speaker_gain_stage(speaker_gain_stage), .half_db_cut(half_db_cut),
    .speaker_gain_db(speaker_gain_db), .anticlip_active(anticlip_active));
  // Crossings are spaced wider than an attack step, so steps can pile up.
  sagc_far_model #(.ZC_PERIOD(200)) sagc_far_model_i (.sys_clk(sys_clk), .rst(rst),
    .speaker_gain_stage(speaker_gain_stage), .supply_mv(supply_mv),
    .headroom_mv(headroom_mv), .zero_cross(zero_cross));
  // Free-running clock at 8 ns.
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int thr_of(input int c);
    return (c <= 10) ? -200 + 50 * c : 400 + 100 * (c - 11);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // The strobe drops for a cycle, so back-to-back writes stay distinct.
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr = a;
    tick(1);
    d = reg_rdata;
  endtask
  task automatic cmp_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_gain(input string what, input logic [5:0] exp, input logic [5:0] got);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic wait_gain(input logic [5:0] exp, input int limit);
    int n;
    n = 0;
    while (speaker_gain_stage !== exp && n < limit)
    begin
      tick(1);
      n++;
    end
    cmp_gain("gain stage", exp, speaker_gain_stage);
  endtask
  task automatic print_verdict();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Level in half-dB; in single-step mode each move is one step.
  assign level_now = {speaker_gain_stage, 1'b0} - 7'(half_db_cut);
  // A step may go either way, since decay raises the level again.
  assign level_step = (level_q - level_now == 7'h01) || (level_now - level_q == 7'h01);
  always @(posedge sys_clk)
  begin
    if (ramp_watch && level_now !== level_q)
      cmp_bit("single step", 1'b1, level_step);
    if (level_q > level_now + 7'h01)
      big_drops++;
    level_q <= level_now;
  end
  // A hang ends the run through the same verdict.
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    bad_count++;
    $display("BAD watchdog expected finish seen hang");
    print_verdict();
  end
  initial
  begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    speaker_gain_setting = 6'h28;
    supply_mv = 13'sd800;
    powerlimit_over = 1'b0;
    voice_bypass_in = 1'b0;
    ramp_watch = 1'b0;
    bad_count = 0;
    checked = 0;
    big_drops = 0;
    lfsr = 32'h0d269b28;
    tick(6);
    rst = 1'b0;
    rd(8'h03);
    cmp_word("enable reset", 16'h0000, d & 16'h4000);
    rd(8'h62);
    cmp_word("anti-clip reset", 16'h8640, d & 16'h8f77);
    rd(8'h64);
    cmp_word("ramp floor reset", 16'h0000, d & 16'h013f);
    rd(8'h10);
    cmp_word("unmapped read", 16'h0000, d);
    $display("test reset_values done");
    repeat (6)
    begin
      lfsr = next_rand(lfsr);
      voice_bypass_in = lfsr[16];
      wr(8'h64, lfsr[15:0]);
      rd(8'h64);
      cmp_word("floor readback", lfsr[15:0] & 16'h013f, d & 16'h013f);
      cmp_bit("bypass", lfsr[16], voice_bypass_out);
    end
    wr(8'h64, 16'h0000);
    tick(1000);
    cmp_gain("gain while off", 6'h28, speaker_gain_stage);
    $display("test random_regs done");
    ramp_watch = 1'b1;
    wr(8'h62, 16'h8600);
    wr(8'h64, 16'h0127);
    wr(8'h03, 16'h4000);
    reg_addr = 8'h64;
    wait_gain(6'h27, 3000);
    tick(500);
    cmp_gain("floor clamp", 6'h27, speaker_gain_stage);
    cmp_bit("half cut at floor", 1'b0, half_db_cut);
    supply_mv = 13'sd2000;
    wait_gain(6'h28, 30000);
    cmp_bit("half cut after step", 1'b1, half_db_cut);
    $display("test attack_decay done");
    supply_mv = 13'sd800;
    wait_gain(6'h27, 3000);
    ramp_watch = 1'b0;
    wr(8'h03, 16'h0000);
    tick(2);
    cmp_gain("release on disable", 6'h28, speaker_gain_stage);
    wr(8'h62, 16'h0600);
    wr(8'h03, 16'h4000);
    tick(1500);
    cmp_gain("anti-clip off", 6'h28, speaker_gain_stage);
    cmp_bit("anti-clip flag off", 1'b0, anticlip_active);
    powerlimit_over = 1'b1;
    wait_gain(6'h27, 3000);
    powerlimit_over = 1'b0;
    wr(8'h03, 16'h0000);
    $display("test release_power done");
    wr(8'h64, 16'h0028);
    wr(8'h03, 16'h4000);
    for (int c = 0; c < 16; c++)
    begin
      wr(8'h62, 16'h8000 | 16'(c << 8));
      supply_mv = 13'(800 + thr_of(c));
      tick(1);
      cmp_bit("at threshold", 1'b1, anticlip_active);
      supply_mv = 13'(810 + thr_of(c));
      tick(1);
      cmp_bit("above threshold", 1'b0, anticlip_active);
    end
    $display("test thresholds done");
    wr(8'h62, 16'h8600);
    wr(8'h64, 16'h0020);
    big_drops = 0;
    supply_mv = 13'sd800;
    tick(2000);
    cmp_bit("multi step", 1'b1, big_drops > 0);
    cmp_bit("cut above floor", 1'b1, speaker_gain_stage < 6'h28 && speaker_gain_stage >= 6'h20);
    $display("test multi_step done");
    print_verdict();
  end
endmodule
